//--- dual_rf_defines.vh
// Constants for the two-element data register file
// How it works
// - Fixed/float naming never changes transfer width
// - Secondary names only in data moves
// - Primary names always address primary element
// - Dual mode computes primary and same-numbered secondary
// - Secondary names always address secondary element
// - Unselected alternate banks hold their contents
// - Bank select takes effect one cycle later
// - Lower and upper halves switch banks independently
// - Mode bits 2, 7, 10 select alternates
// - Mode bit selects alternate foreground and background results
// - Both result registers reachable, accumulate into either
// - Dual add/subtract ORs both flag sets
// - Multifunction operands fixed to four register quarters
// - Shifter excluded from multifunction operations
// - Dual add/subtract writes sum and difference together
// - Fixed multiply pairs freely with ALU op
// - Float multiply pairs with one ALU op
// - Multiply plus dual add/subtract in one cycle
// - Multiply and memory load complete same cycle
// - Mode bit 21 enables secondary element
// - Element enable takes effect one cycle later
// - Dual mode loads, executes, stores both elements
// - 40-bit registers, 32-bit data left-justified
// - Same-cycle read sees old register value
`ifndef DUAL_RF_DEFINES_VH
`define DUAL_RF_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_MODE        4'h0
`define ADDR_EFF_MODE    4'h4
`define ADDR_STATUS      4'h8

// ----------------------------------------
// Mode fields
// ----------------------------------------
`define BIT_ALT_RESULT   2
`define BIT_ALT_UPPER    7
`define BIT_ALT_LOWER    10
`define BIT_SECOND_EN    21
`define MODE_RESET       32'h0000_0000
`define MODE_WMASK       32'h0020_0484

// ----------------------------------------
// Status fields
// ----------------------------------------
`define BIT_BAD_MULTI    0

// ----------------------------------------
// Data widths
// ----------------------------------------
`define DATA_W           40
`define LOW_PAD_W        8
`define FLAG_W           4

`endif

//--- dual_element_register_file.v
// Two-element data register file with alternate banks and result registers
`timescale 1ns/1ps

`include "dual_rf_defines.vh"

module dual_element_register_file #(
	parameter MR_W = 80
) (
	input  wire                 core_clk,
	input  wire                 rst,
	input  wire [3:0]           reg_addr,
	input  wire [31:0]          reg_wdata,
	input  wire                 reg_wr,
	input  wire                 reg_rd,
	output reg  [31:0]          reg_rdata,
	input  wire                 mv_wr,
	input  wire                 mv_rd,
	input  wire                 mv_sec,
	input  wire [3:0]           mv_idx,
	input  wire                 mv_w32,
	input  wire [39:0]          mv_wdata_x,
	input  wire [39:0]          mv_wdata_y,
	output reg  [39:0]          mv_rdata_x,
	output reg  [39:0]          mv_rdata_y,
	input  wire                 op_issue,
	input  wire                 op_multi,
	input  wire                 op_shift,
	input  wire                 op_float,
	input  wire [3:0]           op_mx_idx,
	input  wire [3:0]           op_my_idx,
	input  wire [3:0]           op_ax_idx,
	input  wire [3:0]           op_ay_idx,
	output reg                  op_valid,
	output reg                  op_float_q,
	output reg                  op_dual,
	output reg  [39:0]          op_mx_x,
	output reg  [39:0]          op_my_x,
	output reg  [39:0]          op_ax_x,
	output reg  [39:0]          op_ay_x,
	output reg  [39:0]          op_mx_y,
	output reg  [39:0]          op_my_y,
	output reg  [39:0]          op_ax_y,
	output reg  [39:0]          op_ay_y,
	input  wire                 alu_we,
	input  wire [3:0]           alu_idx,
	input  wire [39:0]          alu_res_x,
	input  wire [39:0]          alu_res_y,
	input  wire [3:0]           alu_flags_x,
	input  wire [3:0]           alu_flags_y,
	input  wire                 alu2_we,
	input  wire [3:0]           alu2_idx,
	input  wire [39:0]          alu2_res_x,
	input  wire [39:0]          alu2_res_y,
	input  wire [3:0]           alu2_flags_x,
	input  wire [3:0]           alu2_flags_y,
	input  wire                 mul_we,
	input  wire [3:0]           mul_idx,
	input  wire [39:0]          mul_res_x,
	input  wire [39:0]          mul_res_y,
	input  wire                 mr_we,
	input  wire                 mr_bg,
	input  wire [MR_W-1:0]      mr_res_x,
	input  wire [MR_W-1:0]      mr_res_y,
	output reg  [MR_W-1:0]      mr_fg_x,
	output reg  [MR_W-1:0]      mr_bg_x,
	output reg  [MR_W-1:0]      mr_fg_y,
	output reg  [MR_W-1:0]      mr_bg_y,
	output reg  [3:0]           alu_flags_q_x,
	output reg  [3:0]           alu_flags_q_y,
	output reg                  dual_mode
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [4:0] phys;
		input [3:0] idx;
		input       alt_up;
		input       alt_lo;
		begin
			phys = {(idx[3] ? alt_up : alt_lo), idx};
		end
	endfunction

	function [39:0] trim32;
		input [39:0] d;
		input        w32;
		begin
			trim32 = w32 ? {d[39:8], 8'h00} : d;
		end
	endfunction

	// ----------------------------------------
	// Mode and status
	// ----------------------------------------
	reg  [31:0] mode_q;
	reg  [31:0] eff_q;
	reg         bad_multi_q;
	wire        alt_up   = eff_q[`BIT_ALT_UPPER];
	wire        alt_lo   = eff_q[`BIT_ALT_LOWER];
	wire        alt_res  = eff_q[`BIT_ALT_RESULT];
	wire        dual     = eff_q[`BIT_SECOND_EN];
	wire        bad_op   = op_issue & op_multi & op_shift;

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_q <= `MODE_RESET;
			eff_q  <= `MODE_RESET;
		end
		else
		begin
			if (reg_wr && reg_addr == `ADDR_MODE)
				mode_q <= reg_wdata & `MODE_WMASK;
			eff_q <= mode_q;
		end
	end

	// ----------------------------------------
	// Multifunction fault flag, set wins over clear
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			bad_multi_q <= 1'b0;
		else if (bad_op)
			bad_multi_q <= 1'b1;
		else if (reg_wr && reg_addr == `ADDR_STATUS && reg_wdata[`BIT_BAD_MULTI])
			bad_multi_q <= 1'b0;
	end

	// ----------------------------------------
	// Register bus read
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata <= 32'h0000_0000;
			dual_mode <= 1'b0;
		end
		else
		begin
			dual_mode <= mode_q[`BIT_SECOND_EN];
			if (reg_rd)
			begin
				case (reg_addr)
				`ADDR_MODE:     reg_rdata <= mode_q;
				`ADDR_EFF_MODE: reg_rdata <= eff_q;
				`ADDR_STATUS:   reg_rdata <= {31'h0000_0000, bad_multi_q};
				default:        reg_rdata <= 32'h0000_0000;
				endcase
			end
			else
				reg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Register arrays, primary and alternate
	// ----------------------------------------
	reg  [39:0] rf_x [0:31];
	reg  [39:0] rf_y [0:31];

	wire [4:0]  mv_p   = phys(mv_idx, alt_up, alt_lo);
	wire [4:0]  alu_p  = phys(alu_idx, alt_up, alt_lo);
	wire [4:0]  alu2_p = phys(alu2_idx, alt_up, alt_lo);
	wire [4:0]  mul_p  = phys(mul_idx, alt_up, alt_lo);

	// Lowest precedence written first; later assignments win
	always @(posedge core_clk)
	begin
		if (mul_we)
		begin
			rf_x[mul_p] <= mul_res_x;
			if (dual)
				rf_y[mul_p] <= mul_res_y;
		end
		if (alu2_we)
		begin
			rf_x[alu2_p] <= alu2_res_x;
			if (dual)
				rf_y[alu2_p] <= alu2_res_y;
		end
		if (alu_we)
		begin
			rf_x[alu_p] <= alu_res_x;
			if (dual)
				rf_y[alu_p] <= alu_res_y;
		end
		if (mv_wr)
		begin
			if (mv_sec)
				rf_y[mv_p] <= trim32(mv_wdata_y, mv_w32);
			else
			begin
				rf_x[mv_p] <= trim32(mv_wdata_x, mv_w32);
				if (dual)
					rf_y[mv_p] <= trim32(mv_wdata_y, mv_w32);
			end
		end
	end

	// ----------------------------------------
	// Data move read
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mv_rdata_x <= 40'h00_0000_0000;
			mv_rdata_y <= 40'h00_0000_0000;
		end
		else if (mv_rd)
		begin
			mv_rdata_x <= mv_sec ? 40'h00_0000_0000 : trim32(rf_x[mv_p], mv_w32);
			mv_rdata_y <= (mv_sec | dual) ? trim32(rf_y[mv_p], mv_w32)
				: 40'h00_0000_0000;
		end
	end

	// ----------------------------------------
	// Multifunction operand quarters
	// ----------------------------------------
	wire [3:0] mx_i = op_multi ? {2'b00, op_mx_idx[1:0]} : op_mx_idx;
	wire [3:0] my_i = op_multi ? {2'b01, op_my_idx[1:0]} : op_my_idx;
	wire [3:0] ax_i = op_multi ? {2'b10, op_ax_idx[1:0]} : op_ax_idx;
	wire [3:0] ay_i = op_multi ? {2'b11, op_ay_idx[1:0]} : op_ay_idx;

	// ----------------------------------------
	// Operand fetch for computations
	// ----------------------------------------
	wire [4:0] mx_p = phys(mx_i, alt_up, alt_lo);
	wire [4:0] my_p = phys(my_i, alt_up, alt_lo);
	wire [4:0] ax_p = phys(ax_i, alt_up, alt_lo);
	wire [4:0] ay_p = phys(ay_i, alt_up, alt_lo);

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			op_valid   <= 1'b0;
			op_float_q <= 1'b0;
			op_dual    <= 1'b0;
			op_mx_x    <= 40'h00_0000_0000;
			op_my_x    <= 40'h00_0000_0000;
			op_ax_x    <= 40'h00_0000_0000;
			op_ay_x    <= 40'h00_0000_0000;
			op_mx_y    <= 40'h00_0000_0000;
			op_my_y    <= 40'h00_0000_0000;
			op_ax_y    <= 40'h00_0000_0000;
			op_ay_y    <= 40'h00_0000_0000;
		end
		else
		begin
			op_valid   <= op_issue & ~bad_op;
			op_float_q <= op_float;
			op_dual    <= op_issue & ~bad_op & dual;
			if (op_issue)
			begin
				op_mx_x <= rf_x[mx_p];
				op_my_x <= rf_x[my_p];
				op_ax_x <= rf_x[ax_p];
				op_ay_x <= rf_x[ay_p];
				op_mx_y <= dual ? rf_y[mx_p] : 40'h00_0000_0000;
				op_my_y <= dual ? rf_y[my_p] : 40'h00_0000_0000;
				op_ax_y <= dual ? rf_y[ax_p] : 40'h00_0000_0000;
				op_ay_y <= dual ? rf_y[ay_p] : 40'h00_0000_0000;
			end
		end
	end

	// ----------------------------------------
	// Multiplier result registers
	// ----------------------------------------
	reg  [MR_W-1:0] mr0_x_q;
	reg  [MR_W-1:0] mr1_x_q;
	reg  [MR_W-1:0] mr0_y_q;
	reg  [MR_W-1:0] mr1_y_q;
	reg  [MR_W-1:0] mr0a_x_q;
	reg  [MR_W-1:0] mr1a_x_q;
	reg  [MR_W-1:0] mr0a_y_q;
	reg  [MR_W-1:0] mr1a_y_q;
	wire            mr_sel = mr_bg;

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mr0_x_q  <= {MR_W{1'b0}};
			mr1_x_q  <= {MR_W{1'b0}};
			mr0_y_q  <= {MR_W{1'b0}};
			mr1_y_q  <= {MR_W{1'b0}};
			mr0a_x_q <= {MR_W{1'b0}};
			mr1a_x_q <= {MR_W{1'b0}};
			mr0a_y_q <= {MR_W{1'b0}};
			mr1a_y_q <= {MR_W{1'b0}};
		end
		else if (mr_we)
		begin
			// Result set chosen by alternate-result bit; others stay intact
			case ({alt_res, mr_sel})
			2'b00:
			begin
				mr0_x_q <= mr_res_x;
				if (dual)
					mr0_y_q <= mr_res_y;
			end
			2'b01:
			begin
				mr1_x_q <= mr_res_x;
				if (dual)
					mr1_y_q <= mr_res_y;
			end
			2'b10:
			begin
				mr0a_x_q <= mr_res_x;
				if (dual)
					mr0a_y_q <= mr_res_y;
			end
			default:
			begin
				mr1a_x_q <= mr_res_x;
				if (dual)
					mr1a_y_q <= mr_res_y;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Result register views
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mr_fg_x <= {MR_W{1'b0}};
			mr_bg_x <= {MR_W{1'b0}};
			mr_fg_y <= {MR_W{1'b0}};
			mr_bg_y <= {MR_W{1'b0}};
		end
		else
		begin
			mr_fg_x <= alt_res ? mr0a_x_q : mr0_x_q;
			mr_bg_x <= alt_res ? mr1a_x_q : mr1_x_q;
			mr_fg_y <= alt_res ? mr0a_y_q : mr0_y_q;
			mr_bg_y <= alt_res ? mr1a_y_q : mr1_y_q;
		end
	end

	// ----------------------------------------
	// ALU flags
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			alu_flags_q_x <= 4'h0;
			alu_flags_q_y <= 4'h0;
		end
		else if (alu_we | alu2_we)
		begin
			alu_flags_q_x <= (alu_we ? alu_flags_x : 4'h0)
				| (alu2_we ? alu2_flags_x : 4'h0);
			if (dual)
				alu_flags_q_y <= (alu_we ? alu_flags_y : 4'h0)
					| (alu2_we ? alu2_flags_y : 4'h0);
		end
	end

endmodule // dual_element_register_file

//--- dual_element_register_file_assertions.sv
// Port checker for the two-element register file
`timescale 1ns/1ps
module dual_rf_checker (
	input logic		core_clk,
	input logic		rst,
	input logic	[3:0]	reg_addr,
	input logic	[31:0]	reg_wdata,
	input logic		reg_wr,
	input logic		mv_rd,
	input logic		mv_sec,
	input logic	[39:0]	mv_rdata_x,
	input logic		op_issue,
	input logic		op_multi,
	input logic		op_shift,
	input logic		op_valid,
	input logic		op_dual,
	input logic	[39:0]	op_ax_y,
	input logic		alu_we,
	input logic		alu2_we,
	input logic	[3:0]	alu_flags_x,
	input logic	[3:0]	alu2_flags_x,
	input logic	[3:0]	alu_flags_q_x,
	input logic		dual_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ----
	// Checks
	// ----
	a_op_latency: assert property (op_issue && !(op_multi && op_shift) |=> op_valid)
		else $error("operands not valid one cycle after issue");
	a_shift_block: assert property (op_issue && op_multi && op_shift |=> !op_valid)
		else $error("shifter multifunction accepted");
	a_valid_cause: assert property (op_valid |-> $past(op_issue))
		else $error("operands valid without issue");
	a_y_single: assert property (op_valid && !op_dual |-> op_ax_y == 40'h0)
		else $error("secondary operand in single mode");
	a_dual_steady: assert property (!$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(dual_mode))
		else $error("element enable moved without write");
	a_dual_write: assert property (reg_wr && reg_addr == 4'h0 ##1 !(reg_wr && reg_addr == 4'h0)
		|-> ##1 dual_mode == $past(reg_wdata[21], 2))
		else $error("element enable not taken from bit 21");
	a_flag_or: assert property (alu_we && alu2_we
		|=> alu_flags_q_x == ($past(alu_flags_x) | $past(alu2_flags_x)))
		else $error("dual flags not ored");
	a_sec_move: assert property (mv_rd && mv_sec |=> mv_rdata_x == 40'h0)
		else $error("secondary move read primary");
endmodule // dual_rf_checker

bind dual_element_register_file dual_rf_checker i_chk (.core_clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .mv_rd, .mv_sec, .mv_rdata_x, .op_issue, .op_multi, .op_shift, .op_valid, .op_dual,
	.op_ax_y, .alu_we, .alu2_we, .alu_flags_x, .alu2_flags_x, .alu_flags_q_x, .dual_mode);

//--- cu_model.sv
// Behavioural ALU and multiplier side
`timescale 1ns/1ps
module cu_model (
	input wire logic		core_clk,
	input wire logic		op_valid,
	input wire logic	[39:0]	ax_x,
	input wire logic	[39:0]	ay_x,
	input wire logic	[39:0]	ax_y,
	input wire logic	[39:0]	ay_y,
	output logic			we = 1'b0,
	output logic	[39:0]	sum_x = 40'h0,
	output logic	[39:0]	sum_y = 40'h0,
	output logic	[39:0]	dif_x = 40'h0,
	output logic	[39:0]	dif_y = 40'h0
);
	// ----
	// Dual add/subtract one cycle after operands
	// ----
	always @(posedge core_clk)
	begin
		we <= op_valid;
		if (op_valid)
		begin
			sum_x <= ax_x + ay_x;
			sum_y <= ax_y + ay_y;
			dif_x <= ax_x - ay_x;
			dif_y <= ax_y - ay_y;
		end
		else
		begin
			sum_x <= ~sum_x;
			sum_y <= ~sum_y;
			dif_x <= ~dif_x;
			dif_y <= ~dif_y;
		end
	end
endmodule // cu_model

//--- dual_element_register_file_tb.sv
// Self-checking bench for the two-element register file
`timescale 1ns/1ps
module dual_element_register_file_tb;
	logic		core_clk = 1'b0;
	logic		rst = 1'b1;
	logic	[3:0]	reg_addr = 4'h0;
	logic	[31:0]	reg_wdata = 32'h0;
	logic		reg_wr = 1'b0;
	logic		reg_rd = 1'b0;
	logic		mv_wr = 1'b0;
	logic		mv_rd = 1'b0;
	logic		mv_sec = 1'b0;
	logic		mv_w32 = 1'b0;
	logic	[3:0]	mv_idx = 4'h0;
	logic	[39:0]	mv_wdata_x = 40'h0;
	logic	[39:0]	mv_wdata_y = 40'h0;
	logic		op_issue = 1'b0;
	logic		op_multi = 1'b0;
	logic		op_shift = 1'b0;
	logic		op_float = 1'b0;
	logic	[3:0]	op_ax_idx = 4'h0;
	logic	[3:0]	op_ay_idx = 4'h0;
	logic	[3:0]	alu_flags_q_x, alu_flags_q_y;
	logic	[79:0]	mr_fg_x, mr_fg_y, mr_bg_x;
	logic	[39:0]	op_my_x;
	logic		op_float_q, op_dual;
	logic	[31:0]	reg_rdata, rv;
	logic	[39:0]	mv_rdata_x, mv_rdata_y, rx, ry, op_ax_x, op_ay_x, op_ax_y, op_ay_y;
	logic	[39:0]	sum_x, sum_y, dif_x, dif_y;
	logic		op_valid, we, dual_mode;
	int		fails = 0;
	int		n_tests = 0;

	dual_element_register_file i_dual_element_register_file (.core_clk, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mv_wr, .mv_rd, .mv_sec, .mv_idx, .mv_w32,
		.mv_wdata_x, .mv_wdata_y, .mv_rdata_x, .mv_rdata_y, .op_issue, .op_multi, .op_shift,
		.op_float, .op_mx_idx(op_ax_idx), .op_my_idx(op_ay_idx), .op_ax_idx, .op_ay_idx,
		.op_valid, .op_float_q, .op_dual, .op_mx_x(), .op_my_x, .op_ax_x, .op_ay_x,
		.op_mx_y(), .op_my_y(), .op_ax_y, .op_ay_y, .alu_we(we), .alu_idx(4'h0),
		.alu_res_x(sum_x), .alu_res_y(sum_y), .alu_flags_x(sum_x[3:0]),
		.alu_flags_y(sum_y[3:0]), .alu2_we(we), .alu2_idx(4'h1), .alu2_res_x(dif_x),
		.alu2_res_y(dif_y), .alu2_flags_x(dif_x[3:0]), .alu2_flags_y(dif_y[3:0]), .mul_we(we),
		.mul_idx(4'h2), .mul_res_x(sum_x ^ dif_x), .mul_res_y(sum_y ^ dif_y), .mr_we(we),
		.mr_bg(1'b0), .mr_res_x({sum_x, dif_x}), .mr_res_y({sum_y, dif_y}), .mr_fg_x,
		.mr_bg_x, .mr_fg_y, .mr_bg_y(), .alu_flags_q_x, .alu_flags_q_y, .dual_mode);

	cu_model i_cu_model (.core_clk, .op_valid, .ax_x(op_ax_x), .ay_x(op_ay_x), .ax_y(op_ax_y),
		.ay_y(op_ay_y), .we, .sum_x, .sum_y, .dif_x, .dif_y);

	// ----
	// Access tasks
	// ----
	task chk(input logic [39:0] g, input logic [39:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask

	task mv(input logic r, input logic s, input logic [3:0] i, input logic w,
		input logic [39:0] x, input logic [39:0] y);
		@(posedge core_clk);
		mv_sec <= s;
		mv_idx <= i;
		mv_w32 <= w;
		mv_wdata_x <= x;
		mv_wdata_y <= y;
		mv_rd <= r;
		mv_wr <= !r;
		@(posedge core_clk);
		mv_rd <= 1'b0;
		mv_wr <= 1'b0;
		#1;
		rx = mv_rdata_x;
		ry = mv_rdata_y;
	endtask

	task op(input logic m, input logic s, input logic [3:0] a, input logic [3:0] b,
		input logic f);
		@(posedge core_clk);
		op_multi <= m;
		op_float <= f;
		op_shift <= s;
		op_ax_idx <= a;
		op_ay_idx <= b;
		op_issue <= 1'b1;
		@(posedge core_clk);
		op_issue <= 1'b0;
		#1;
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----
	// Clock and sequence
	// ----
	initial
		forever #25 core_clk = ~core_clk;

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h0);
		chk(rv, 40'h0);
		chk(dual_mode, 40'h0);
		wr(4'h0, 32'hffff_ffff);
		rd(4'h0);
		chk(rv, 40'h0020_0484);
		chk(dual_mode, 40'h1);
		rd(4'hc);
		chk(rv, 40'h0);
		wr(4'h0, 32'h0);
		$display("mode test done");
		mv(0, 0, 4'h3, 0, 40'h12_3456_78ff, 40'h0);
		mv(0, 0, 4'h4, 1, 40'h12_3456_78ff, 40'h0);
		mv(0, 1, 4'h3, 0, 40'h0, 40'hab_cdef_0123);
		mv(1, 0, 4'h3, 0, 40'h0, 40'h0);
		chk(rx, 40'h12_3456_78ff);
		chk(ry, 40'h0);
		mv(1, 0, 4'h3, 1, 40'h0, 40'h0);
		chk(rx, 40'h12_3456_7800);
		mv(1, 0, 4'h4, 0, 40'h0, 40'h0);
		chk(rx, 40'h12_3456_7800);
		mv(1, 1, 4'h3, 0, 40'h0, 40'h0);
		chk(ry, 40'hab_cdef_0123);
		$display("move test done");
		mv(0, 0, 4'h1, 0, 40'h11, 40'h0);
		mv(0, 0, 4'h9, 0, 40'h99, 40'h0);
		wr(4'h0, 32'h400);
		mv(0, 0, 4'h1, 0, 40'h22, 40'h0);
		mv(1, 0, 4'h9, 0, 40'h0, 40'h0);
		chk(rx, 40'h99);
		mv(1, 0, 4'h1, 0, 40'h0, 40'h0);
		chk(rx, 40'h22);
		wr(4'h0, 32'h0);
		mv(1, 0, 4'h1, 0, 40'h0, 40'h0);
		chk(rx, 40'h11);
		$display("bank test done");
		mv(0, 0, 4'h8, 0, 40'h10_0000_0005, 40'h0);
		mv(0, 0, 4'hc, 0, 40'h3, 40'h0);
		mv(0, 1, 4'h8, 0, 40'h0, 40'h7);
		mv(0, 1, 4'hc, 0, 40'h0, 40'h9);
		wr(4'h0, 32'h0020_0000);
		op(1, 0, 4'h4, 4'h0, 0);
		chk(op_valid, 40'h1);
		chk(op_dual, 40'h1);
		chk(op_ax_x, 40'h10_0000_0005);
		chk(op_ay_x, 40'h3);
		chk(op_my_x, 40'h12_3456_7800);
		chk(op_ax_y, 40'h7);
		chk(op_ay_y, 40'h9);
		repeat (3) @(posedge core_clk);
		#1;
		chk(alu_flags_q_x, 40'ha);
		chk(alu_flags_q_y, 40'he);
		chk(mr_fg_x[79:40], 40'h10_0000_0008);
		chk(mr_fg_y[39:0], 40'hff_ffff_fffe);
		chk(mr_bg_x[39:0], 40'h0);
		mv(1, 0, 4'h0, 0, 40'h0, 40'h0);
		chk(rx, 40'h10_0000_0008);
		chk(ry, 40'h10);
		mv(1, 0, 4'h1, 0, 40'h0, 40'h0);
		chk(rx, 40'h10_0000_0002);
		chk(ry, 40'hff_ffff_fffe);
		mv(1, 0, 4'h2, 0, 40'h0, 40'h0);
		chk(rx, 40'h00_0000_000a);
		chk(ry, 40'hff_ffff_ffee);
		op(1, 1, 4'h4, 4'h0, 0);
		chk(op_valid, 40'h0);
		rd(4'h8);
		chk(rv, 40'h1);
		wr(4'h8, 32'h1);
		rd(4'h8);
		chk(rv, 40'h0);
		wr(4'h0, 32'h0);
		op(0, 0, 4'h8, 4'hc, 1);
		chk(op_ax_x, 40'h10_0000_0005);
		chk(op_ay_y, 40'h0);
		chk(op_float_q, 40'h1);
		chk(op_dual, 40'h0);
		$display("compute test done");
		test_done();
	end
endmodule // dual_element_register_file_tb
